//--- rtl/led_blink_pkg.sv
// constants and types shared by the status led sequencer and its blink code engine
// assumes a single 25 mhz system clock and a synchronous active high reset
`default_nettype none
package led_blink_pkg;
   // ----------------------------------------------------------------
   // clock and prescaled tick
   // ----------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 40;
   localparam int unsigned TICK_PERIOD_NS = 1000000;
   // one millisecond tick, rounded up to whole clocks
   localparam int unsigned TICK_CYCLES = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned PRESC_W = 16;
   // ----------------------------------------------------------------
   // intervals in milliseconds
   // ----------------------------------------------------------------
   localparam int unsigned MS_W = 12;
   localparam logic [MS_W-1:0] FLICK_HALF_MS = 12'h032;  // 50 ms, 10 hz flicker
   localparam logic [MS_W-1:0] GAP_MS = 12'h3e8;         // 1000 ms pause
   localparam logic [MS_W-1:0] PULSE_HALF_MS = 12'h1f4;  // 500 ms, 1 hz pulses
   localparam logic [MS_W-1:0] FLASH2_HALF_MS = 12'h0fa; // 250 ms, 2 hz flash
   localparam logic [MS_W-1:0] INIT_HALF_MS = 12'h032;   // 50 ms, rapid orange
   localparam logic [7:0] FLICK_PULSES = 8'h0a;          // ten flashes in one second
   // ----------------------------------------------------------------
   // error codes of the blink sequence
   // ----------------------------------------------------------------
   localparam logic [3:0] ERR_HW_CFG = 4'h1;
   localparam logic [3:0] ERR_CONFIG = 4'h2;
   localparam logic [3:0] ERR_PROTOCOL = 4'h3;
   localparam logic [3:0] ERR_PHYSICAL = 4'h4;
   localparam logic [3:0] ERR_INIT = 4'h5;
   localparam logic [3:0] ERR_UNUSED_6 = 4'h6;
   localparam logic [3:0] ERR_UNSUPPORTED = 4'h7;
   localparam logic [3:0] ERR_UNUSED_8 = 4'h8;
   localparam logic [3:0] ERR_CPU_EXC = 4'h9;
   // ----------------------------------------------------------------
   // blink code engine states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      S_IDLE,
      S_FLICK,
      S_GAP1,
      S_CODE,
      S_GAP2,
      S_ARG,
      S_GAP3
   } seq_state_type;
endpackage : led_blink_pkg
`default_nettype wire

//--- rtl/blink_seq_if.sv
// bundle between the led selector and one blink code engine
// assumes both ends run on the same system clock
`default_nettype none
interface blink_seq_if;
   logic tick;        // one millisecond pulse
   logic enable;      // error present, run the sequence
   logic [3:0] code;  // error code to show
   logic [7:0] arg;   // error argument to show
   logic led_on;      // engine wants the led lit
   logic busy;        // engine is inside a sequence
   modport ctrl (output tick, output enable, output code, output arg,
                 input led_on, input busy);
   modport seq (input tick, input enable, input code, input arg,
                output led_on, output busy);
endinterface : blink_seq_if
`default_nettype wire

//--- rtl/blink_code_engine.sv
// three group blink code engine: flicker, gap, code pulses, gap, argument pulses, gap
// assumes tick is a one clock pulse every millisecond from the same clock
`default_nettype none
module blink_code_engine (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic srst_i,
   // link to the selector
   blink_seq_if.seq bus
);
   import led_blink_pkg::*;

   seq_state_type state_reg, state_next;
   logic [MS_W-1:0] ms_reg, ms_next;
   logic phase_reg, phase_next;
   logic [7:0] left_reg, left_next;
   logic [3:0] code_reg, code_next;
   logic [7:0] arg_reg, arg_next;
   logic [7:0] seen_reg, seen_next;

   // ----------------------------------------------------------------
   // interval decode
   // ----------------------------------------------------------------
   wire logic [MS_W-1:0] limit = (state_reg == S_FLICK) ? FLICK_HALF_MS :
                                 (state_reg == S_CODE || state_reg == S_ARG) ? PULSE_HALF_MS :
                                 GAP_MS;
   wire logic period_end = bus.tick && (ms_reg == limit - 12'h001);
   wire logic pulsing = (state_reg == S_FLICK) || (state_reg == S_CODE) || (state_reg == S_ARG);
   wire logic group_done = period_end && !phase_reg && (left_reg <= 8'h01);

   // next state of the sequence
   always_comb begin
      state_next = state_reg;
      ms_next = bus.tick ? ms_reg + 12'h001 : ms_reg;
      phase_next = phase_reg;
      left_next = left_reg;
      code_next = code_reg;
      arg_next = arg_reg;
      if (period_end) begin
         ms_next = '0;
      end
      if (!bus.enable) begin
         state_next = S_IDLE;
         phase_next = 1'b0;
         ms_next = '0;
      end else begin
         case (state_reg)
            S_IDLE, S_GAP3: begin
               if (state_reg == S_IDLE || period_end) begin
                  state_next = S_FLICK;
                  code_next = bus.code;
                  arg_next = bus.arg;
                  left_next = FLICK_PULSES;
                  phase_next = 1'b1;
                  ms_next = '0;
               end
            end
            S_FLICK, S_CODE, S_ARG: begin
               if (period_end && phase_reg) begin
                  phase_next = 1'b0;
               end else if (group_done) begin
                  state_next = (state_reg == S_FLICK) ? S_GAP1 :
                               (state_reg == S_CODE) ? S_GAP2 : S_GAP3;
               end else if (period_end) begin
                  left_next = left_reg - 8'h01;
                  phase_next = 1'b1;
               end
            end
            S_GAP1: begin
               if (period_end) begin
                  state_next = (code_reg == 4'h0) ? S_GAP2 : S_CODE;
                  left_next = {4'h0, code_reg};
                  phase_next = (code_reg != 4'h0);
               end
            end
            S_GAP2: begin
               if (period_end) begin
                  state_next = (arg_reg == 8'h00) ? S_GAP3 : S_ARG;
                  left_next = arg_reg;
                  phase_next = (arg_reg != 8'h00);
               end
            end
            default: begin
               state_next = S_IDLE;
               phase_next = 1'b0;
            end
         endcase
      end
   end

   // pulses seen in the current group, read by the checks below
   assign seen_next = (state_next != state_reg) ? {7'h00, phase_next} :
                      seen_reg + {7'h00, (phase_next && !phase_reg)};

   // state registers
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         state_reg <= S_IDLE;
         ms_reg <= '0;
         phase_reg <= 1'b0;
         left_reg <= 8'h00;
         code_reg <= 4'h0;
         arg_reg <= 8'h00;
         seen_reg <= 8'h00;
      end else begin
         state_reg <= state_next;
         ms_reg <= ms_next;
         phase_reg <= phase_next;
         left_reg <= left_next;
         code_reg <= code_next;
         arg_reg <= arg_next;
         seen_reg <= seen_next;
      end
   end

   assign bus.led_on = phase_reg && pulsing;
   assign bus.busy = (state_reg != S_IDLE);

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (srst_i);

   a_gap_dark: assert property (
      (state_reg == S_GAP1 || state_reg == S_GAP2 || state_reg == S_GAP3) |-> !bus.led_on)
      else $error("led lit during a pause");
   a_flick_count: assert property (
      (state_reg == S_FLICK && state_next == S_GAP1) |-> seen_reg == FLICK_PULSES)
      else $error("wrong number of flicker flashes");
   a_code_count: assert property (
      (state_reg == S_CODE && state_next == S_GAP2) |-> seen_reg == {4'h0, code_reg})
      else $error("code pulse count differs from code");
   a_arg_count: assert property (
      (state_reg == S_ARG && state_next == S_GAP3) |-> seen_reg == arg_reg)
      else $error("argument pulse count differs from argument");
   a_cycle_restart: assert property (
      (state_reg == S_GAP3 && state_next != S_GAP3 && bus.enable) |=> state_reg == S_FLICK)
      else $error("sequence did not restart with flicker");
endmodule : blink_code_engine
`default_nettype wire

//--- rtl/led_blink_code_sequencer.sv
// status led driver: selects steady colour, flash or blink code for the bus led, and blink code only for the module led
// assumes all status inputs come from logic on clk_sys_i; leds are driven red and green
//
// Behaviour
// - bus led steady green while local bus data cycles run normally
// - bus led flashes orange rapidly while the local bus initialises
// - bus led steady red while a hardware fault is present
// - bus led flashes red at two hertz for a recoverable error
// - bus led shows the red blink code while a local bus error is present
// - bus led off while the support library is missing or not called
// - each diagnosis repeats as three groups: preamble, code, argument
// - preamble is a one second flicker at about ten hertz
// - about one second of darkness follows the preamble and the code group
// - the code group has as many pulses as the error code
// - code and argument pulses run at about one hertz, one per unit
// - after a pause the argument group pulses as many times as the argument
// - a bus break argument counts the last working module before the break
// - after the argument the sequence restarts from the flicker while the error stays
// - error codes 1 to 9 as defined, codes 6 and 8 unused
// - module status led shows its diagnosis with the same blink code
`default_nettype none
module led_blink_code_sequencer #(
   parameter int unsigned TICK_CYCLES = led_blink_pkg::TICK_CYCLES
) (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic srst_i,
   // local bus status
   input wire logic lib_ready_i,
   input wire logic bus_running_i,
   input wire logic bus_init_i,
   input wire logic hw_fault_i,
   input wire logic recov_err_i,
   input wire logic bus_err_i,
   input wire logic [3:0] bus_err_code_i,
   input wire logic [7:0] bus_err_arg_i,
   // module diagnosis
   input wire logic mod_err_i,
   input wire logic [3:0] mod_err_code_i,
   input wire logic [7:0] mod_err_arg_i,
   // bus status led, orange is both lit
   output logic bus_status_led_red_o,
   output logic bus_status_led_green_o,
   // module status led
   output logic module_status_led_red_o,
   output logic module_status_led_green_o
);
   import led_blink_pkg::*;

   // ----------------------------------------------------------------
   // millisecond tick
   // ----------------------------------------------------------------
   logic [PRESC_W-1:0] presc_reg, presc_next;
   logic tick_reg, tick_next;

   // the tick is registered so both engines and flashers see it in the same cycle
   assign tick_next = (presc_reg == PRESC_W'(TICK_CYCLES - 1));
   assign presc_next = tick_next ? '0 : presc_reg + PRESC_W'(1);

   // prescaler registers
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         presc_reg <= '0;
         tick_reg <= 1'b0;
      end else begin
         presc_reg <= presc_next;
         tick_reg <= tick_next;
      end
   end

   // ----------------------------------------------------------------
   // plain flashers
   // ----------------------------------------------------------------
   // advance a half period counter, wrapping at the limit
   function automatic logic [MS_W-1:0] half_count(input logic [MS_W-1:0] cnt,
                                                  input logic tick,
                                                  input logic [MS_W-1:0] limit);
      logic [MS_W-1:0] res;
      res = cnt;
      if (tick) begin
         res = (cnt == limit - 12'h001) ? '0 : cnt + 12'h001;
      end
      return res;
   endfunction : half_count

   logic [MS_W-1:0] f2_cnt_reg, f2_cnt_next;
   logic [MS_W-1:0] init_cnt_reg, init_cnt_next;
   logic f2_reg, f2_next;
   logic init_reg, init_next;

   // two hertz red flash and rapid orange flash
   assign f2_cnt_next = half_count(f2_cnt_reg, tick_reg, FLASH2_HALF_MS);
   assign f2_next = (tick_reg && f2_cnt_reg == FLASH2_HALF_MS - 12'h001) ? !f2_reg : f2_reg;
   assign init_cnt_next = half_count(init_cnt_reg, tick_reg, INIT_HALF_MS);
   assign init_next = (tick_reg && init_cnt_reg == INIT_HALF_MS - 12'h001) ? !init_reg :
                      init_reg;

   // flasher registers
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         f2_cnt_reg <= '0;
         init_cnt_reg <= '0;
         f2_reg <= 1'b0;
         init_reg <= 1'b0;
      end else begin
         f2_cnt_reg <= f2_cnt_next;
         init_cnt_reg <= init_cnt_next;
         f2_reg <= f2_next;
         init_reg <= init_next;
      end
   end

   // ----------------------------------------------------------------
   // blink code engines
   // ----------------------------------------------------------------
   // priority: hardware fault, missing library, bus error, recoverable, init, running
   // declared here because the bus engine enable reads sel_err
   wire logic sel_fault = hw_fault_i;
   wire logic sel_off = !sel_fault && !lib_ready_i;
   wire logic sel_err = !sel_fault && lib_ready_i && bus_err_i;
   wire logic sel_recov = !sel_fault && lib_ready_i && !bus_err_i && recov_err_i;
   wire logic sel_init = !sel_fault && lib_ready_i && !bus_err_i && !recov_err_i && bus_init_i;
   wire logic sel_run = !sel_fault && lib_ready_i && !bus_err_i && !recov_err_i &&
                        !bus_init_i && bus_running_i;

   blink_seq_if bus_seq ();
   blink_seq_if mod_seq ();

   // the bus engine only runs when the bus error is the shown condition
   assign bus_seq.tick = tick_reg;
   assign bus_seq.enable = sel_err;
   assign bus_seq.code = bus_err_code_i;
   assign bus_seq.arg = bus_err_arg_i;
   assign mod_seq.tick = tick_reg;
   assign mod_seq.enable = mod_err_i;
   assign mod_seq.code = mod_err_code_i;
   assign mod_seq.arg = mod_err_arg_i;

   blink_code_engine u_bus_engine (
      .clk_sys_i (clk_sys_i),
      .srst_i (srst_i),
      .bus (bus_seq.seq)
   );

   blink_code_engine u_mod_engine (
      .clk_sys_i (clk_sys_i),
      .srst_i (srst_i),
      .bus (mod_seq.seq)
   );

   // ----------------------------------------------------------------
   // bus led selection
   // ----------------------------------------------------------------
   logic bus_red_reg, bus_red_next;
   logic bus_green_reg, bus_green_next;
   logic mod_red_reg, mod_red_next;

   // colour of the bus led for the chosen condition
   assign bus_red_next = sel_fault ||
                         (sel_err && bus_seq.led_on) ||
                         (sel_recov && f2_reg) ||
                         (sel_init && init_reg);
   assign bus_green_next = (sel_init && init_reg) ||
                           sel_run;
   // sel_off leaves both colours dark
   assign mod_red_next = mod_err_i && mod_seq.led_on;

   // led output registers
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         bus_red_reg <= 1'b0;
         bus_green_reg <= 1'b0;
         mod_red_reg <= 1'b0;
      end else begin
         bus_red_reg <= bus_red_next;
         bus_green_reg <= bus_green_next;
         mod_red_reg <= mod_red_next;
      end
   end

   assign bus_status_led_red_o = bus_red_reg;
   assign bus_status_led_green_o = bus_green_reg;
   assign module_status_led_red_o = mod_red_reg;
   assign module_status_led_green_o = 1'b0; // module led only reports in red

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (srst_i);

   // a rise of the two hertz flash: dark in one cycle, lit in the next
   sequence s_flash_rise;
      !f2_reg ##1 f2_reg;
   endsequence

   a_tick_prescale: assert property (
      tick_reg |-> (presc_reg == '0) ##1 !tick_reg)
      else $error("tick not aligned to prescaler wrap");
   a_fault_red: assert property (
      hw_fault_i |=> bus_status_led_red_o && !bus_status_led_green_o)
      else $error("hardware fault not steady red");
   a_lib_off: assert property (
      (!hw_fault_i && !lib_ready_i) |=> !bus_status_led_red_o && !bus_status_led_green_o)
      else $error("led not off with library missing");
   a_run_green: assert property (
      sel_run |=> bus_status_led_green_o && !bus_status_led_red_o)
      else $error("running bus not steady green");
   a_init_orange: assert property (
      sel_init |=> bus_status_led_red_o == bus_status_led_green_o &&
                   bus_status_led_red_o == $past(init_reg))
      else $error("init flash not orange");
   a_flash2_rate: assert property (
      s_flash_rise |-> $past(tick_reg) && $past(f2_cnt_reg) == FLASH2_HALF_MS - 12'h001)
      else $error("two hertz flash toggled off its period");
   a_err_code: assert property (
      sel_err |=> bus_status_led_red_o == $past(bus_seq.led_on) && !bus_status_led_green_o)
      else $error("bus error not shown as blink code");
   a_mod_code: assert property (
      mod_err_i |=> module_status_led_red_o == $past(mod_seq.led_on))
      else $error("module led does not follow blink code");
   a_err_starts: assert property (
      $rose(sel_err) |-> ##[1:2] bus_seq.busy)
      else $error("blink code did not start");
endmodule : led_blink_code_sequencer
`default_nettype wire

//--- sim/led_observer.sv
// operator model of one status led: counts pulse groups split by long dark spans
// assumes the led level is a registered output sampled on the system clock
`default_nettype none
module led_observer #(
   parameter int DARK_LIM = 3200
) (
   // clock and control
   input wire logic clk_sys_i,
   input wire logic clr_i,
   // watched led element
   input wire logic led_i
);
   timeunit 1ns;
   timeprecision 1ps;
   int grp_q[$];  // pulses per finished group
   int wid_q[$];  // last high width of each group, in clocks
   int gap_q[$];  // dark span before each group, in clocks
   int cnt;
   int high;
   int dark;
   int last_high;
   logic prev;
   // --------------------------------------------------------------
   // group recogniser: a dark span of DARK_LIM clocks ends a group
   // --------------------------------------------------------------
   always @(posedge clk_sys_i) begin
      if (clr_i) begin
         grp_q.delete();
         wid_q.delete();
         gap_q.delete();
         cnt = 0;
         high = 0;
         dark = 0;
      end else if (led_i === 1'b1) begin
         if (!prev && cnt == 0) gap_q.push_back(dark);
         if (!prev) cnt++;
         high++;
         dark = 0;
      end else begin
         if (prev) last_high = high;
         high = 0;
         dark++;
         if (dark == DARK_LIM && cnt != 0) begin
            grp_q.push_back(cnt);
            wid_q.push_back(last_high);
            cnt = 0;
         end
      end
      prev = (led_i === 1'b1);
   end
endmodule : led_observer
`default_nettype wire

//--- sim/led_blink_code_sequencer_tb_top.sv
// self-checking bench of the status led sequencer, tick shortened to 4 clocks
// assumes the design package and interface are compiled before this file
`default_nettype none
module led_blink_code_sequencer_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TK = 4;  // clocks per millisecond tick
   logic clk_sys_i, srst_i, lib_ready_i, bus_running_i, bus_init_i, hw_fault_i;
   logic recov_err_i, bus_err_i, mod_err_i, clr;
   logic [3:0] bus_err_code_i, mod_err_code_i;
   logic [7:0] bus_err_arg_i, mod_err_arg_i;
   logic bus_red, bus_green, mod_red, mod_green;
   int num_errors = 0;
   int n_checks = 0;
   // --------------------------------------------------------------
   // design and operator models
   // --------------------------------------------------------------
   led_blink_code_sequencer #(.TICK_CYCLES(TK)) led_blink_code_sequencer_inst (
      .clk_sys_i(clk_sys_i), .srst_i(srst_i), .lib_ready_i(lib_ready_i),
      .bus_running_i(bus_running_i), .bus_init_i(bus_init_i), .hw_fault_i(hw_fault_i),
      .recov_err_i(recov_err_i), .bus_err_i(bus_err_i), .bus_err_code_i(bus_err_code_i),
      .bus_err_arg_i(bus_err_arg_i), .mod_err_i(mod_err_i), .mod_err_code_i(mod_err_code_i),
      .mod_err_arg_i(mod_err_arg_i), .bus_status_led_red_o(bus_red),
      .bus_status_led_green_o(bus_green), .module_status_led_red_o(mod_red),
      .module_status_led_green_o(mod_green));
   led_observer #(.DARK_LIM(800 * TK)) led_observer_inst (
      .clk_sys_i(clk_sys_i), .clr_i(clr), .led_i(bus_red));
   led_observer #(.DARK_LIM(800 * TK)) led_observer_mod_inst (
      .clk_sys_i(clk_sys_i), .clr_i(clr), .led_i(mod_red));
   // --------------------------------------------------------------
   // clock, compare and closing
   // --------------------------------------------------------------
   initial begin
      clk_sys_i = 1'b0;
      forever #20 clk_sys_i = ~clk_sys_i;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic close_out();
      $display("checks %0d, mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : close_out
   // wait a few edges then look at settled levels
   task automatic settle();
      repeat (3) @(posedge clk_sys_i);
      #1;
   endtask : settle
   // high width of the next bus red pulse, in clocks
   task automatic red_width(output int w);
      int n;
      w = 0;
      n = 0;
      while (bus_red !== 1'b0 && n < 5000) begin @(posedge clk_sys_i); #1; n++; end
      while (bus_red !== 1'b1 && n < 5000) begin @(posedge clk_sys_i); #1; n++; end
      while (bus_red === 1'b1 && n < 5000) begin @(posedge clk_sys_i); #1; n++; w++; end
   endtask : red_width
   // --------------------------------------------------------------
   // scenarios
   // --------------------------------------------------------------
   task automatic t_steady();
      @(posedge clk_sys_i) bus_running_i <= 1'b1;
      settle();
      check({bus_red, bus_green}, 2'b01);
      @(posedge clk_sys_i) lib_ready_i <= 1'b0;
      settle();
      check({bus_red, bus_green}, 2'b00);
      @(posedge clk_sys_i) hw_fault_i <= 1'b1;
      settle();
      check({bus_red, bus_green}, 2'b10);
      @(posedge clk_sys_i) begin hw_fault_i <= 1'b0; lib_ready_i <= 1'b1; end
      settle();
      check({bus_red, bus_green}, 2'b01);
      $display("test steady done");
   endtask : t_steady
   task automatic t_flash();
      int w;
      @(posedge clk_sys_i) recov_err_i <= 1'b1;
      red_width(w);
      red_width(w);
      check((w >= 250 * TK - TK) && (w <= 250 * TK + TK), 1);
      check(bus_green, 1'b0);
      @(posedge clk_sys_i) begin recov_err_i <= 1'b0; bus_init_i <= 1'b1; end
      red_width(w);
      red_width(w);
      check((w >= 50 * TK - TK) && (w <= 50 * TK + TK), 1);
      repeat (30) begin @(posedge clk_sys_i); #1; check(bus_green, bus_red); end
      @(posedge clk_sys_i) bus_init_i <= 1'b0;
      $display("test flash done");
   endtask : t_flash
   task automatic t_blink();
      int n;
      @(posedge clk_sys_i) begin
         clr <= 1'b1;
         bus_err_code_i <= 4'h2;
         bus_err_arg_i <= 8'h01;
         mod_err_code_i <= 4'h1;
         mod_err_arg_i <= 8'h03;
      end
      @(posedge clk_sys_i) begin clr <= 1'b0; bus_err_i <= 1'b1; mod_err_i <= 1'b1; end
      n = 0;
      while (led_observer_inst.grp_q.size() < 4 && n < 40000) begin
         @(posedge clk_sys_i);
         #1;
         if (bus_green !== 1'b0 || mod_green !== 1'b0) check({bus_green, mod_green}, 2'b00);
         n++;
      end
      check(led_observer_inst.grp_q.size() >= 4, 1);
      if (led_observer_inst.grp_q.size() >= 4) begin
         check(led_observer_inst.grp_q[0], 10);
         check(led_observer_inst.wid_q[0], 50 * TK);
         check(led_observer_inst.grp_q[1], 2);
         check(led_observer_inst.wid_q[1], 500 * TK);
         check(led_observer_inst.grp_q[2], 1);
         check(led_observer_inst.grp_q[3], 10);
         n = led_observer_inst.gap_q[1];
         check((n >= 1000 * TK - TK) && (n <= 1050 * TK + TK), 1);
      end
      check(led_observer_mod_inst.grp_q.size() >= 3, 1);
      if (led_observer_mod_inst.grp_q.size() >= 3) begin
         check(led_observer_mod_inst.grp_q[1], 1);
         check(led_observer_mod_inst.grp_q[2], 3);
      end
      @(posedge clk_sys_i) begin bus_err_i <= 1'b0; mod_err_i <= 1'b0; end
      settle();
      check({bus_red, bus_green, mod_red}, 3'b010);
      $display("test blink done");
   endtask : t_blink
   // --------------------------------------------------------------
   // main sequence and watchdog
   // --------------------------------------------------------------
   initial begin
      srst_i = 1'b1;
      clr = 1'b1;
      lib_ready_i = 1'b1;
      {bus_running_i, bus_init_i, hw_fault_i, recov_err_i, bus_err_i, mod_err_i} = 6'h00;
      {bus_err_code_i, mod_err_code_i, bus_err_arg_i, mod_err_arg_i} = 24'h000000;
      repeat (4) @(posedge clk_sys_i);
      srst_i <= 1'b0;
      settle();
      check({bus_red, bus_green, mod_red, mod_green}, 4'h0);
      t_steady();
      t_flash();
      t_blink();
      close_out();
   end
   initial begin
      repeat (60000) @(posedge clk_sys_i);
      num_errors++;
      $display("watchdog expired at %0t ns", $time);
      close_out();
   end
endmodule : led_blink_code_sequencer_tb_top
`default_nettype wire
